//--- verilog/rx_format_pkg.sv
// constants, codes and carriers shared by the receive format unit
package rx_format_pkg;
   // ************************************************************
   // widths, depths and register selects
   // ************************************************************
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 32;
   localparam logic [1:0] SEL_FORMAT = 2'h0;
   localparam logic [1:0] SEL_MASK = 2'h1;
   localparam logic [1:0] SEL_BUFFER = 2'h2;
   localparam logic [1:0] SEL_STATUS = 2'h3;
   // ************************************************************
   // reset values and writable bits
   // ************************************************************
   localparam logic [31:0] FORMAT_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] FORMAT_WMASK = 32'h0003_FFFF;
   // ************************************************************
   // field codes and status bit positions
   // ************************************************************
   localparam logic [1:0] PAD_ZERO = 2'h0;
   localparam logic [1:0] PAD_ONE = 2'h1;
   localparam logic [1:0] PAD_COPY = 2'h2;
   localparam logic [1:0] DELAY_MAX = 2'h2;
   localparam int ROT_STEP = 4;
   localparam int ST_RUN = 0;
   localparam int ST_DATA = 1;
   localparam int ST_OVERRUN = 2;
   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic [13:0] zero;
      logic [1:0] rx_first_bit_delay;
      logic rx_bit_order_reverse;
      logic [1:0] rx_pad_select;
      logic [4:0] rx_pad_bit_index;
      logic [3:0] rx_slot_size;
      logic rx_read_port_select;
      logic [2:0] rx_rotate_amount;
   } fmt_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] sel;
      logic [31:0] wdata;
   } cfg_req_s;
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_WAIT = 2'b01,
      LINK_SHIFT = 2'b11
   } link_state_e;
endpackage

//--- verilog/receive_format_unit.sv
// receive format unit: slot assembly, format stages, buffer, read ports

// ************************************************************
// receive word buffer
// ************************************************************
module rx_word_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // full and empty come straight from the occupancy count
   assign in_ready = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage has no reset: only written words are ever read
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data;
   end

   // pointers wrap; depth is a power of two
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule

// ************************************************************
// top of the receive format unit
// ************************************************************
module receive_format_unit
#(
   parameter int FIFO_WORDS = rx_format_pkg::FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // receive state machine release, from global control
   input wire logic rx_sm_enable,
   // configuration bus
   input wire rx_format_pkg::cfg_req_s cfg_req,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // data port
   input wire logic dat_rd,
   output logic [31:0] dat_rdata,
   output logic dat_rvalid,
   // serial link
   input wire logic rx_bit_clock,
   input wire logic rx_frame_sync,
   input wire logic serial_data_line
);
   import rx_format_pkg::*;

   fmt_s fmt_reg;
   logic [31:0] rx_bit_mask_reg;
   logic run_reg;
   logic overrun_reg;
   logic run_meta;
   logic run_sync;
   logic fs_prev;
   link_state_e state_reg;
   logic [1:0] wait_reg;
   logic [5:0] cnt_reg;
   logic [1:0] lk_delay_reg;
   logic [5:0] lk_last_reg;
   logic [31:0] word_reg;
   logic [31:0] hold_reg;
   logic tog_reg;
   logic fs_edge;
   logic first_bit;
   logic shift_bit;
   logic [31:0] word_full;
   logic tog_meta;
   logic tog_sync;
   logic tog_prev;
   logic new_word;
   logic [31:0] cap_reg;
   logic pend_reg;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [31:0] fifo_out_data;
   logic pop_cfg;
   logic pop_dat;
   logic [31:0] rev_word;
   logic [31:0] rot_word;
   logic [31:0] fmt_word;
   logic [63:0] rot_pair;
   logic pad_value;

   // ************************************************************
   // configuration registers
   // ************************************************************
   // changing format mid-stream would mix settings within a slot
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fmt_reg <= fmt_s'(FORMAT_RESET);
         rx_bit_mask_reg <= MASK_RESET;
      end
      else if (cfg_req.wr && !run_reg)
      begin
         if (cfg_req.sel == SEL_FORMAT)
            fmt_reg <= fmt_s'(cfg_req.wdata & FORMAT_WMASK);
         if (cfg_req.sel == SEL_MASK)
            rx_bit_mask_reg <= cfg_req.wdata;
      end
   end

   // receiver release, also the source of the link-side enable
   always_ff @(posedge clk)
   begin
      if (rst)
         run_reg <= 1'b0;
      else
         run_reg <= rx_sm_enable;
   end

   // ************************************************************
   // link domain: slot assembly on the bit clock
   // ************************************************************
   // enable crosses as a level through two flops
   always_ff @(posedge rx_bit_clock)
   begin
      run_meta <= run_reg;
      run_sync <= run_meta;
   end

   // settings are static while running, so a held-off copy is safe
   always_ff @(posedge rx_bit_clock)
   begin
      if (!run_sync)
      begin
         lk_delay_reg <= (fmt_reg.rx_first_bit_delay > DELAY_MAX) ?
            DELAY_MAX : fmt_reg.rx_first_bit_delay;
         // (code|1 + 1) * 2 - 1 reduces to the upper code bits then 11
         lk_last_reg <= {1'b0, fmt_reg.rx_slot_size[3:1], 2'b11};
      end
   end

   assign fs_edge = rx_frame_sync && !fs_prev;
   assign first_bit = run_sync && ((fs_edge && lk_delay_reg == 2'd0) ||
      (!fs_edge && state_reg == LINK_WAIT && wait_reg == 2'd0) ||
      (!fs_edge && state_reg == LINK_SHIFT && cnt_reg == 6'd0));
   assign shift_bit = run_sync && !fs_edge && state_reg == LINK_SHIFT &&
      cnt_reg != 6'd0;

   // merge the current bit so the last one is not a cycle late
   always_comb
   begin
      word_full = word_reg;
      word_full[cnt_reg[4:0]] = serial_data_line;
   end

   // frame sync restarts the slot count from any state
   always_ff @(posedge rx_bit_clock)
   begin
      fs_prev <= rx_frame_sync;
      if (!run_sync)
      begin
         state_reg <= LINK_IDLE;
         cnt_reg <= 6'd0;
         wait_reg <= 2'd0;
      end
      else if (fs_edge && lk_delay_reg == 2'd0)
      begin
         state_reg <= LINK_SHIFT;
         cnt_reg <= 6'd1;
      end
      else if (fs_edge)
      begin
         state_reg <= LINK_WAIT;
         wait_reg <= lk_delay_reg - 2'd1;
      end
      else
      begin
         case (state_reg)
            LINK_WAIT:
               if (wait_reg == 2'd0)
               begin
                  state_reg <= LINK_SHIFT;
                  cnt_reg <= 6'd1;
               end
               else
                  wait_reg <= wait_reg - 2'd1;
            LINK_SHIFT:
               cnt_reg <= (cnt_reg == lk_last_reg) ? 6'd0 :
                  cnt_reg + 6'd1;
            default:
               cnt_reg <= 6'd0;
         endcase
      end
   end

   // bits land at their arrival index: first bit is bit 0
   always_ff @(posedge rx_bit_clock)
   begin
      if (first_bit)
         word_reg <= {31'd0, serial_data_line};
      else if (shift_bit)
         word_reg <= word_full;
   end

   // completed slot is parked and announced by a toggle
   always_ff @(posedge rx_bit_clock)
   begin
      if (!run_sync)
         tog_reg <= 1'b0;
      else if (shift_bit && cnt_reg == lk_last_reg)
      begin
         hold_reg <= word_full;
         tog_reg <= !tog_reg;
      end
   end

   // ************************************************************
   // system domain: capture and format
   // ************************************************************
   // hold_reg is stable for a whole slot after the toggle moves
   always_ff @(posedge clk)
   begin
      tog_meta <= tog_reg;
      tog_sync <= tog_meta;
      tog_prev <= rst ? 1'b0 : tog_sync;
   end

   assign new_word = run_reg && (tog_sync != tog_prev);

   // one word waits here while the buffer is full
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pend_reg <= 1'b0;
         cap_reg <= '0;
      end
      else if (new_word && (!pend_reg || fifo_in_ready))
      begin
         pend_reg <= 1'b1;
         cap_reg <= hold_reg;
      end
      else if (fifo_in_ready)
         pend_reg <= 1'b0;
   end

   // a word arriving on a stalled pending word is lost and flagged
   always_ff @(posedge clk)
   begin
      if (rst)
         overrun_reg <= 1'b0;
      else if (new_word && pend_reg && !fifo_in_ready)
         overrun_reg <= 1'b1;
      else if (cfg_req.rd && cfg_req.sel == SEL_STATUS)
         overrun_reg <= 1'b0;
   end

   // bit reversal over the full word, then rotation
   generate
      for (genvar i = 0; i < DATA_W; i++)
      begin : g_rev
         assign rev_word[i] = fmt_reg.rx_bit_order_reverse ?
            cap_reg[DATA_W-1-i] : cap_reg[i];
      end
   endgenerate

   assign rot_pair = {rev_word, rev_word} >>
      (fmt_reg.rx_rotate_amount * ROT_STEP);
   assign rot_word = rot_pair[31:0];

   // reserved pad code falls back to zero fill
   always_comb
   begin
      case (fmt_reg.rx_pad_select)
         PAD_ZERO: pad_value = 1'b0;
         PAD_ONE: pad_value = 1'b1;
         PAD_COPY: pad_value = rot_word[fmt_reg.rx_pad_bit_index];
         default: pad_value = 1'b0;
      endcase
   end

   // masking sees the already reversed and rotated word
   generate
      for (genvar i = 0; i < DATA_W; i++)
      begin : g_mask
         assign fmt_word[i] = rx_bit_mask_reg[i] ? rot_word[i] :
            pad_value;
      end
   endgenerate

   rx_word_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(pend_reg),
      .in_ready(fifo_in_ready),
      .in_data(fmt_word),
      .out_valid(fifo_out_valid),
      .out_ready(pop_cfg || pop_dat),
      .out_data(fifo_out_data)
   );

   // ************************************************************
   // read ports
   // ************************************************************
   assign pop_cfg = cfg_req.rd && cfg_req.sel == SEL_BUFFER &&
      fmt_reg.rx_read_port_select && fifo_out_valid;
   assign pop_dat = dat_rd && !fmt_reg.rx_read_port_select &&
      fifo_out_valid;

   // bus always answers; a refused buffer read returns zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg_rvalid <= 1'b0;
         cfg_rdata <= '0;
      end
      else
      begin
         cfg_rvalid <= cfg_req.rd;
         case (cfg_req.sel)
            SEL_FORMAT: cfg_rdata <= 32'(fmt_reg) & FORMAT_WMASK;
            SEL_MASK: cfg_rdata <= rx_bit_mask_reg;
            SEL_BUFFER: cfg_rdata <= pop_cfg ? fifo_out_data : '0;
            default:
            begin
               cfg_rdata <= '0;
               cfg_rdata[ST_RUN] <= run_reg;
               cfg_rdata[ST_DATA] <= fifo_out_valid;
               cfg_rdata[ST_OVERRUN] <= overrun_reg;
            end
         endcase
      end
   end

   // data port stays silent while the bus owns the buffer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dat_rvalid <= 1'b0;
         dat_rdata <= '0;
      end
      else
      begin
         dat_rvalid <= dat_rd && !fmt_reg.rx_read_port_select;
         dat_rdata <= pop_dat ? fifo_out_data : '0;
      end
   end
endmodule

//--- verification/rx_link_model.sv
// transmitter model driving the receive serial link
module rx_link_model
(
   // serial link
   output logic rx_bit_clock,
   output logic rx_frame_sync,
   output logic serial_data_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // link drive
   // ********
   // clock stands low outside bursts; idle data toggles so nothing stale
   initial
   begin
      rx_bit_clock = 1'b0;
      rx_frame_sync = 1'b0;
      serial_data_line = 1'b0;
   end
   // bit clocks with frame sync low, data changed on the falling edge
   task automatic clocks(input int k);
      repeat (k)
      begin
         serial_data_line = ~serial_data_line;
         #15 rx_bit_clock = 1'b1;
         #15 rx_bit_clock = 1'b0;
      end
   endtask
   // one frame of one slot, LSB first, first bit dly clocks after sync
   task automatic send(input logic [31:0] w, input int n, input int dly);
      for (int k = 0; k < n + dly; k++)
      begin
         rx_frame_sync = (k == 0);
         serial_data_line = (k >= dly) ? w[k - dly] : ~serial_data_line;
         #15 rx_bit_clock = 1'b1;
         #15 rx_bit_clock = 1'b0;
      end
      rx_frame_sync = 1'b0;
      clocks(2);
   endtask
endmodule

//--- verification/rx_format_checker.sv
// port-level assertions for the receive format unit
module rx_format_checker
#(
   parameter int FIFO_WORDS = 32
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control and buses
   input wire logic rx_sm_enable,
   input wire rx_format_pkg::cfg_req_s cfg_req,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic dat_rd,
   input wire logic dat_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   import rx_format_pkg::*;
   logic run_reg;
   logic [31:0] fmt_reg;
   // shadow format, locked while the receiver runs
   always_ff @(posedge clk)
   begin
      run_reg <= rst ? 1'b0 : rx_sm_enable;
      if (rst)
         fmt_reg <= FORMAT_RESET;
      else if (cfg_req.wr && cfg_req.sel == SEL_FORMAT && !run_reg)
         fmt_reg <= cfg_req.wdata & FORMAT_WMASK;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ********
   // properties
   // ********
   property p_rd_answer; cfg_req.rd |=> cfg_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("config read not answered");
   property p_rd_only; !cfg_req.rd |=> !cfg_rvalid; endproperty
   a_rd_only: assert property (p_rd_only)
      else $error("config answer without read");
   property p_dat_cause; dat_rvalid |-> $past(dat_rd); endproperty
   a_dat_cause: assert property (p_dat_cause)
      else $error("data port answer without read");
   property p_dat_refused; dat_rd && fmt_reg[3] |=> !dat_rvalid; endproperty
   a_dat_refused: assert property (p_dat_refused)
      else $error("data port served while bus selected");
   property p_dat_served; dat_rd && !fmt_reg[3] |=> dat_rvalid; endproperty
   a_dat_served: assert property (p_dat_served)
      else $error("data port read not served");
   property p_buf_cfg_ignored;
      cfg_req.rd && cfg_req.sel == SEL_BUFFER && !fmt_reg[3]
         |=> cfg_rdata == 32'h0000_0000;
   endproperty
   a_buf_cfg_ignored: assert property (p_buf_cfg_ignored)
      else $error("buffer served on config bus");
   property p_fmt_zero;
      cfg_rvalid && $past(cfg_req.sel) == SEL_FORMAT
         |-> cfg_rdata[31:18] == 14'h0000;
   endproperty
   a_fmt_zero: assert property (p_fmt_zero)
      else $error("format upper bits not zero");
   property p_fmt_readback;
      cfg_rvalid && $past(cfg_req.sel) == SEL_FORMAT |-> cfg_rdata == fmt_reg;
   endproperty
   a_fmt_readback: assert property (p_fmt_readback)
      else $error("format changed while running");
endmodule
bind receive_format_unit rx_format_checker #(.FIFO_WORDS(FIFO_WORDS)) chk
(
   .clk(clk), .rst(rst), .rx_sm_enable(rx_sm_enable), .cfg_req(cfg_req),
   .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .dat_rd(dat_rd),
   .dat_rvalid(dat_rvalid)
);

//--- verification/testbench.sv
// self-checking testbench for the receive format unit
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rx_format_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rx_sm_enable = 1'b0;
   cfg_req_s cfg_req = '0;
   logic dat_rd = 1'b0;
   logic [31:0] cfg_rdata, dat_rdata;
   logic cfg_rvalid, dat_rvalid, bclk, fsync, sdata;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   receive_format_unit #(.FIFO_WORDS(FIFO_DEPTH)) uut
   (
      .clk(clk), .rst(rst), .rx_sm_enable(rx_sm_enable), .cfg_req(cfg_req),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .dat_rd(dat_rd),
      .dat_rdata(dat_rdata), .dat_rvalid(dat_rvalid), .rx_bit_clock(bclk),
      .rx_frame_sync(fsync), .serial_data_line(sdata)
   );
   rx_link_model link
   (
      .rx_bit_clock(bclk), .rx_frame_sync(fsync), .serial_data_line(sdata)
   );
   // ********
   // clock, timeout and verdict
   // ********
   initial
   begin
      forever #5 clk = ~clk;
   end
   // ceiling well above the few thousand cycles the tests need
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         $display("MISMATCH at %0t: timeout", $time);
         stop_test();
      end
   end
   task automatic stop_test;
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // ********
   // access tasks; answers are sampled just after the answering edge
   // ********
   task automatic wr(input logic [1:0] sel, input logic [31:0] d);
      @(posedge clk);
      cfg_req <= '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: d};
      @(posedge clk);
      cfg_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] sel, output logic [31:0] d);
      @(posedge clk);
      cfg_req <= '{wr: 1'b0, rd: 1'b1, sel: sel, wdata: 32'h0000_0000};
      @(posedge clk);
      cfg_req.rd <= 1'b0;
      #1 d = cfg_rdata;
   endtask
   task automatic drd(output logic v, output logic [31:0] d);
      @(posedge clk);
      dat_rd <= 1'b1;
      @(posedge clk);
      dat_rd <= 1'b0;
      #1 v = dat_rvalid;
      d = dat_rdata;
   endtask
   // expected word: reverse, rotate right, then pad where mask is zero
   function automatic logic [31:0] fmt_word(input logic [31:0] raw,
      input fmt_s f, input logic [31:0] m);
      logic [31:0] r;
      logic [63:0] d;
      logic pb;
      for (int b = 0; b < 32; b++)
         r[b] = f.rx_bit_order_reverse ? raw[31 - b] : raw[b];
      d = {r, r} >> (4 * f.rx_rotate_amount);
      r = d[31:0];
      pb = (f.rx_pad_select == 2'h1) ? 1'b1 : 1'b0;
      if (f.rx_pad_select == 2'h2)
         pb = r[f.rx_pad_bit_index];
      return (r & m) | (~m & {32{pb}});
   endfunction
   // run the link around a burst: settings latch only while disabled
   task automatic frame(input logic [31:0] w, input int n, input int dly);
      link.clocks(4);
      @(posedge clk) rx_sm_enable <= 1'b1;
      wr(SEL_FORMAT, 32'h0000_0000);
      link.clocks(4);
      link.send(w, n, dly);
   endtask
   // ********
   // main sequence
   // ********
   initial
   begin
      logic v;
      logic [31:0] d, raw, m;
      fmt_s f;
      int n;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(SEL_FORMAT, d);
      check(d, 32'h0000_0000);
      wr(SEL_FORMAT, 32'hFFFF_FFFF);
      rd(SEL_FORMAT, d);
      check(d, 32'h0003_FFFF);
      // delay and pad codes 0 to 2, odd sizes 3 to 15, every rotate code, both orders and ports
      for (int i = 0; i < 8; i++)
      begin
         f = '{rx_first_bit_delay: 2'(i % 3), rx_bit_order_reverse: i[0],
            rx_pad_select: 2'(i % 3), rx_pad_bit_index: 5'(i * 9),
            rx_slot_size: 4'(2 * (i % 7) + 3), rx_read_port_select: i[1],
            rx_rotate_amount: 3'(i), default: '0};
         m = 32'hF0F0_3CFF >> i;
         n = 2 * (int'(f.rx_slot_size) + 1);
         raw = 32'(64'h96E1_A5C3_5A3C_0FF0 >> (i * 4));
         raw = raw & 32'((64'h1 << n) - 1);
         wr(SEL_FORMAT, f);
         wr(SEL_MASK, m);
         frame(raw, n, int'(f.rx_first_bit_delay));
         repeat (10) @(posedge clk);
         if (f.rx_read_port_select)
         begin
            drd(v, d);
            check(32'(v), 32'h0000_0000);
            rd(SEL_BUFFER, d);
         end
         else
         begin
            rd(SEL_BUFFER, d);
            check(d, 32'h0000_0000);
            drd(v, d);
         end
         check(d, fmt_word(raw, f, m));
         @(posedge clk) rx_sm_enable <= 1'b0;
         repeat (2) @(posedge clk);
         rd(SEL_FORMAT, d);
         check(d, f);
      end
      // fill the buffer past its depth, then drain it through the port
      wr(SEL_FORMAT, 32'h0000_0030);
      wr(SEL_MASK, 32'h0000_00FF);
      frame(32'h0000_00A5, 8, 0);
      for (int k = 0; k < FIFO_DEPTH + 1; k++)
         link.send(32'(k), 8, 0);
      repeat (10) @(posedge clk);
      rd(SEL_STATUS, d);
      check(d, 32'h0000_0007);
      drd(v, d);
      check(d, 32'h0000_00A5);
      for (int k = 0; k < FIFO_DEPTH; k++)
      begin
         drd(v, d);
         check(d, 32'(k));
      end
      drd(v, d);
      check(d, 32'h0000_0000);
      stop_test();
   end
endmodule
